// File: hash_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries writes, readback and per-frame lookup into the hash table
interface hash_mem_if;
   logic wr_en;
   logic wr_sel;
   logic [3:0] wr_strb;
   logic [31:0] wr_data;
   logic rd_sel;
   logic [31:0] rd_data;
   logic [5:0] look_index;
   logic look_bit;
   modport ctrl (output wr_en, wr_sel, wr_strb, wr_data, rd_sel, look_index,
                 input rd_data, look_bit);
   modport mem (input wr_en, wr_sel, wr_strb, wr_data, rd_sel, look_index,
                output rd_data, look_bit);
endinterface
`default_nettype wire

// File: hash_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
module hash_table_mem (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   hash_mem_if.mem port
);
   logic [31:0] word_reg [2];
   logic [31:0] word_next [2];
   logic [31:0] rd_data_reg;
   logic look_bit_reg;

   // ---------------------------------------------------------------
   // Byte-lane writes, one generate branch per word
   // ---------------------------------------------------------------
   genvar g;
   for (g = 0; g < 2; g++) begin : g_word
      always_comb begin
         word_next[g] = word_reg[g];
         for (int b = 0; b < 4; b++) begin
            if (port.wr_en && (port.wr_sel == 1'(g)) && port.wr_strb[b]) begin
               word_next[g][b*8 +: 8] = port.wr_data[b*8 +: 8];
            end
         end
      end
      always_ff @(posedge i_clk_sys) begin
         if (i_reset) begin
            word_reg[g] <= 32'h0000_0000;
         end else begin
            word_reg[g] <= word_next[g];
         end
      end
   end

   // Both read ports registered; lookup sees the table one edge late
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rd_data_reg <= 32'h0000_0000;
         look_bit_reg <= 1'b0;
      end else begin
         rd_data_reg <= word_reg[port.rd_sel];
         look_bit_reg <= word_reg[port.look_index[5]][port.look_index[4:0]];
      end
   end

   assign port.rd_data = rd_data_reg;
   assign port.look_bit = look_bit_reg;
endmodule
`default_nettype wire

// File: rx_filter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Filter checker
// ----------------------------------------
module rx_filter_asserts (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [3:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [3:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic i_frame_valid,
   input wire logic i_frame_wake_found,
   input wire logic i_frame_dest_own_unicast,
   input wire logic i_frame_csum_match,
   input wire logic o_frame_done,
   input wire logic o_frame_accept
);
   logic [15:0] cfg;
   logic [3:0] rd_addr;
   wire logic csok = i_frame_csum_match ^ cfg[12];
   wire logic uniok = csok & i_frame_wake_found & i_frame_dest_own_unicast;
   wire logic quiet = i_frame_valid && cfg[15:14] == 2'b00;
   // Config shadow; takes every address-0 write offered with AW and W together as a full word, ignoring strobes
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cfg <= 16'h0000;
         rd_addr <= 4'h0;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
             && i_s_axi_awaddr == 4'h0) begin
            cfg <= i_s_axi_wdata[15:0];
         end
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            rd_addr <= i_s_axi_araddr;
         end
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   done_latency_a: assert property (i_frame_valid |-> ##2 o_frame_done)
      else $error("frame done late or missing");
   done_source_a: assert property (o_frame_done |-> $past(i_frame_valid, 2))
      else $error("frame done without a frame");
   accept_gate_a: assert property (o_frame_accept |-> o_frame_done)
      else $error("accept outside done");
   wake_accept_a: assert property (i_frame_valid && cfg[14] && i_frame_wake_found |-> ##2 o_frame_accept)
      else $error("wake frame refused");
   mode_off_a: assert property (quiet && cfg[11:8] == 4'h0 |-> ##2 !o_frame_accept)
      else $error("mode off accepted");
   reserved_mode_a: assert property (quiet && cfg[11:8] == 4'hf |-> ##2 !o_frame_accept)
      else $error("reserved mode accepted");
   csum_select_a: assert property (quiet && cfg[11:8] == 4'h3 |-> ##2 o_frame_accept == $past(csok, 2))
      else $error("checksum sense wrong");
   unicast_mode_a: assert property (quiet && cfg[11:8] == 4'h9 |-> ##2 o_frame_accept == $past(uniok, 2))
      else $error("unicast wake mode wrong");
   bit13_read_a: assert property (o_s_axi_rvalid && rd_addr == 4'h0 |-> !o_s_axi_rdata[13])
      else $error("config bit 13 reads one");
   cover property (i_frame_valid && cfg[14] && i_frame_wake_found ##2 o_frame_accept);
   cover property (quiet && cfg[11:8] == 4'h9 ##2 o_frame_accept);
   cover property (o_s_axi_rvalid && rd_addr == 4'h0);
endmodule
bind rx_filter_top rx_filter_asserts rx_filter_asserts_inst (.*);
`default_nettype wire

// File: rx_filter_pkg.sv
package rx_filter_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_FILTER_CFG = 4'h0;
   localparam logic [3:0] ADDR_HASH_LO = 4'h4;
   localparam logic [3:0] ADDR_HASH_HI = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;

   // ---------------------------------------------------------------
   // Filter configuration fields
   // ---------------------------------------------------------------
   localparam int HASH_EN_BIT = 15;
   localparam int WAKE_EN_BIT = 14;
   localparam int UNUSED_BIT = 13;
   localparam int INVERT_BIT = 12;
   localparam int MODE_MSB = 11;
   localparam int MODE_LSB = 8;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // Bit 13 has no storage and reads as zero
   localparam logic [15:0] CFG_WRITE_MASK = 16'hdfff;

   // ---------------------------------------------------------------
   // Pattern-match mode codes
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_WAKE_UNICAST = 4'h9;
   localparam logic [3:0] MODE_RESERVED = 4'hf;

   // ---------------------------------------------------------------
   // Status fields and bus answers
   // ---------------------------------------------------------------
   localparam int ST_ACCEPT_BIT = 0;
   localparam int ST_HASH_BIT = 1;
   localparam int ST_WAKE_BIT = 2;
   localparam int ST_PATTERN_BIT = 3;
   localparam int ST_COUNT_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: rx_filter_top.sv
`timescale 1ns/1ps
`default_nettype none
module rx_filter_top (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [3:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [3:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_frame_valid,
   input wire logic [5:0] i_frame_hash_index,
   input wire logic i_frame_wake_found,
   input wire logic i_frame_dest_own_unicast,
   input wire logic i_frame_csum_match,
   output logic o_frame_done,
   output logic o_frame_accept
);
   hash_mem_if hmem ();

   hash_table_mem hash_table_mem_inst (
      .i_clk_sys (i_clk_sys),
      .i_reset (i_reset),
      .port (hmem.mem)
   );

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic [3:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [15:0] cfg_reg, cfg_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic do_write;
   logic [15:0] cfg_wmask;

   // Address and data taken in either order; write fires once both held
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      cfg_next = cfg_reg;
      do_write = aw_held_reg && w_held_reg && !bvalid_reg;
      cfg_wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & rx_filter_pkg::CFG_WRITE_MASK;
      if (o_s_axi_awready && i_s_axi_awvalid) begin
         aw_held_next = 1'b1;
         awaddr_next = i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
         w_held_next = 1'b1;
         wdata_next = i_s_axi_wdata;
         wstrb_next = i_s_axi_wstrb;
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = rx_filter_pkg::RESP_OKAY;
         case (awaddr_reg)
            rx_filter_pkg::ADDR_FILTER_CFG: begin
               cfg_next = (cfg_reg & ~cfg_wmask) | (wdata_reg[15:0] & cfg_wmask);
            end
            rx_filter_pkg::ADDR_HASH_LO, rx_filter_pkg::ADDR_HASH_HI,
            rx_filter_pkg::ADDR_STATUS: begin
               bresp_next = rx_filter_pkg::RESP_OKAY;
            end
            default: begin
               bresp_next = rx_filter_pkg::RESP_SLVERR;
            end
         endcase
      end else if (bvalid_reg && i_s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      // Readies low while the matching half is held or the answer waits
      awready_next = !aw_held_next && !bvalid_next;
      wready_next = !w_held_next && !bvalid_next;
   end

   // Hash words go straight to the table in the firing cycle
   assign hmem.wr_en = do_write && ((awaddr_reg == rx_filter_pkg::ADDR_HASH_LO) ||
                                    (awaddr_reg == rx_filter_pkg::ADDR_HASH_HI));
   assign hmem.wr_sel = (awaddr_reg == rx_filter_pkg::ADDR_HASH_HI);
   assign hmem.wr_strb = wstrb_reg;
   assign hmem.wr_data = wdata_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         cfg_reg <= rx_filter_pkg::CFG_RESET;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         cfg_reg <= cfg_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
      end
   end

   // Ready flags straight from their registers
   assign o_s_axi_awready = awready_reg;
   assign o_s_axi_wready = wready_reg;
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_ANSWER} rd_state_t;
   rd_state_t rd_state_reg, rd_state_next;
   logic [3:0] araddr_reg, araddr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] status_word;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;

   // Table readback is registered, so one fetch cycle precedes the answer
   always_comb begin
      rd_state_next = rd_state_reg;
      araddr_next = araddr_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (i_s_axi_arvalid) begin
               araddr_next = i_s_axi_araddr;
               rd_state_next = RD_FETCH;
            end
         end
         RD_FETCH: begin
            rd_state_next = RD_ANSWER;
            rresp_next = rx_filter_pkg::RESP_OKAY;
            case (araddr_reg)
               rx_filter_pkg::ADDR_FILTER_CFG: rdata_next = {16'h0000, cfg_reg};
               rx_filter_pkg::ADDR_HASH_LO: rdata_next = hmem.rd_data;
               rx_filter_pkg::ADDR_HASH_HI: rdata_next = hmem.rd_data;
               rx_filter_pkg::ADDR_STATUS: rdata_next = status_word;
               default: begin
                  rdata_next = 32'h0000_0000;
                  rresp_next = rx_filter_pkg::RESP_SLVERR;
               end
            endcase
         end
         RD_ANSWER: begin
            if (i_s_axi_rready) begin
               rd_state_next = RD_IDLE;
            end
         end
         default: begin
            rd_state_next = RD_IDLE;
         end
      endcase
      arready_next = (rd_state_next == RD_IDLE);
      rvalid_next = (rd_state_next == RD_ANSWER);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rd_state_reg <= RD_IDLE;
         araddr_reg <= 4'h0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end else begin
         rd_state_reg <= rd_state_next;
         araddr_reg <= araddr_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Select from the incoming address so the registered word is ready in fetch
   assign hmem.rd_sel = (araddr_next == rx_filter_pkg::ADDR_HASH_HI);
   assign o_s_axi_arready = arready_reg;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;

   // ---------------------------------------------------------------
   // Frame decision: stage 1 waits on the table lookup
   // ---------------------------------------------------------------
   logic st1_valid_reg;
   logic st1_wake_reg, st1_unicast_reg, st1_csum_reg;
   logic done_reg, done_next, accept_reg, accept_next;
   logic [3:0] hits_reg, hits_next;
   logic [15:0] count_reg, count_next;
   logic hash_hit, wake_hit, csum_ok, mode_ok, pattern_hit;
   logic [3:0] mode;

   assign hmem.look_index = i_frame_hash_index;
   assign mode = cfg_reg[rx_filter_pkg::MODE_MSB:rx_filter_pkg::MODE_LSB];

   always_comb begin
      hash_hit = cfg_reg[rx_filter_pkg::HASH_EN_BIT] && hmem.look_bit;
      wake_hit = cfg_reg[rx_filter_pkg::WAKE_EN_BIT] && st1_wake_reg;
      // Inversion flips which checksum outcome counts as success
      csum_ok = cfg_reg[rx_filter_pkg::INVERT_BIT] ? !st1_csum_reg : st1_csum_reg;
      case (mode)
         rx_filter_pkg::MODE_OFF: mode_ok = 1'b0;
         rx_filter_pkg::MODE_WAKE_UNICAST: mode_ok = st1_wake_reg && st1_unicast_reg;
         rx_filter_pkg::MODE_RESERVED: mode_ok = 1'b0;
         default: mode_ok = 1'b1;
      endcase
      pattern_hit = csum_ok && mode_ok;
      done_next = st1_valid_reg;
      accept_next = 1'b0;
      hits_next = hits_reg;
      count_next = count_reg;
      if (st1_valid_reg) begin
         accept_next = hash_hit || wake_hit || pattern_hit;
         hits_next = {pattern_hit, wake_hit, hash_hit, accept_next};
         if (accept_next) begin
            count_next = count_reg + 16'h0001; // Wraps silently
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st1_valid_reg <= 1'b0;
         st1_wake_reg <= 1'b0;
         st1_unicast_reg <= 1'b0;
         st1_csum_reg <= 1'b0;
         done_reg <= 1'b0;
         accept_reg <= 1'b0;
         hits_reg <= 4'h0;
         count_reg <= 16'h0000;
      end else begin
         st1_valid_reg <= i_frame_valid;
         st1_wake_reg <= i_frame_wake_found;
         st1_unicast_reg <= i_frame_dest_own_unicast;
         st1_csum_reg <= i_frame_csum_match;
         done_reg <= done_next;
         accept_reg <= accept_next;
         hits_reg <= hits_next;
         count_reg <= count_next;
      end
   end

   assign status_word = {count_reg, 12'h000, hits_reg};
   assign o_frame_done = done_reg;
   assign o_frame_accept = accept_reg;
endmodule
`default_nettype wire

// File: rx_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Receive datapath model
// ----------------------------------------
module rx_frame_src (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_send,
   input wire logic [8:0] i_attr,
   output logic o_frame_valid,
   output logic [8:0] o_attr
);
   // Valid copies i_send one edge late; attributes flip between frames so stale values never pass
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_frame_valid <= 1'b0;
         o_attr <= 9'h000;
      end else begin
         o_frame_valid <= i_send;
         o_attr <= i_send ? i_attr : ~o_attr;
      end
   end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Filter testbench
// ----------------------------------------
module tb;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic [3:0] i_s_axi_awaddr = 4'h0;
   logic [3:0] i_s_axi_araddr = 4'h0;
   logic [31:0] i_s_axi_wdata = 32'h0;
   logic [3:0] i_s_axi_wstrb = 4'hf;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
   logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, send = 1'b0;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic [31:0] o_s_axi_rdata, seed = 32'h35;
   logic i_frame_valid, o_frame_done, o_frame_accept;
   logic [8:0] attr = 9'h000, f_attr;
   logic [63:0] ht = 64'h0;
   wire logic [5:0] i_frame_hash_index = f_attr[8:3];
   wire logic i_frame_wake_found = f_attr[2];
   wire logic i_frame_dest_own_unicast = f_attr[1];
   wire logic i_frame_csum_match = f_attr[0];
   logic fq[$];
   logic [33:0] bq[$];
   int n_errors = 0, compares = 0, cyc = 0, n_acc = 0;
   rx_filter_top rx_filter_top_inst (.*);
   rx_frame_src rx_frame_src_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_send(send),
      .i_attr(attr), .o_frame_valid(i_frame_valid), .o_attr(f_attr));
   always #2.5 i_clk_sys = ~i_clk_sys;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Reference decision from the config word, table and frame flags
   function automatic logic exp_acc(input logic [15:0] c, input logic [8:0] f);
      logic ok;
      logic mo;
      ok = c[rx_filter_pkg::INVERT_BIT] ^ f[0];
      case (c[11:8])
         4'h0, 4'hf: mo = 1'b0;
         4'h9: mo = f[2] & f[1];
         default: mo = 1'b1;
      endcase
      return (c[15] & ht[f[8:3]]) | (c[14] & f[2]) | (ok & mo);
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      bq.push_back({e, 32'h0});
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      end while (o_s_axi_bvalid !== 1'b1);
      i_s_axi_bready <= 1'b0;
      // One idle edge so a following call never re-raises bready in this step
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      bq.push_back(e);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (o_s_axi_rvalid !== 1'b1);
      i_s_axi_rready <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic frame(input logic [15:0] c);
      logic [31:0] r;
      logic e;
      r = xs();
      e = exp_acc(c, r[8:0]);
      fq.push_back(e);
      n_acc += e;
      send <= 1'b1;
      attr <= r[8:0];
      @(posedge i_clk_sys);
   endtask
   task automatic bus_chk(input logic [33:0] g);
      compares++;
      if (bq.size() == 0 || g !== bq.pop_front()) begin
         n_errors++;
         $display("unexpected at %0t: bus answer %h", $time, g);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Monitor: each answer against the oldest note; hang guard
   always @(posedge i_clk_sys) begin
      cyc++;
      if (o_frame_done === 1'b1) begin
         compares++;
         if (fq.size() == 0 || o_frame_accept !== fq.pop_front()) begin
            n_errors++;
            $display("unexpected at %0t: frame accept %b", $time, o_frame_accept);
         end
      end
      if (o_s_axi_bvalid === 1'b1 && i_s_axi_bready) bus_chk({o_s_axi_bresp, 32'h0});
      if (o_s_axi_rvalid === 1'b1 && i_s_axi_rready) bus_chk({o_s_axi_rresp, o_s_axi_rdata});
      if (cyc == 5000) begin
         n_errors++;
         $display("unexpected at %0t: timeout", $time);
         end_sim();
      end
   end
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] c;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(4'h0, {2'b00, 16'h0, rx_filter_pkg::CFG_RESET});
      rd(4'h4, 34'h0);
      wr(4'h2, 32'h0, 2'b10);
      rd(4'h2, {2'b10, 32'h0});
      wr(4'h0, 32'hffffffff, 2'b00);
      rd(4'h0, {2'b00, 32'h0000dfff});
      // Low lane only: upper byte keeps its value
      i_s_axi_wstrb <= 4'h1;
      wr(4'h0, 32'h0000_0000, 2'b00);
      i_s_axi_wstrb <= 4'hf;
      rd(4'h0, {2'b00, 32'h0000df00});
      ht = {xs(), xs()};
      wr(4'h4, ht[31:0], 2'b00);
      wr(4'h8, ht[63:32], 2'b00);
      rd(4'h4, {2'b00, ht[31:0]});
      rd(4'h8, {2'b00, ht[63:32]});
      $display("test done: registers");
      for (int i = 0; i < 128; i++) begin
         r = xs();
         c = {i[6], i[5], 1'b0, i[4], i[3:0], r[7:0]};
         wr(4'h0, {16'h0, c}, 2'b00);
         repeat (4) frame(c);
         send <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
      end
      $display("test done: filters");
      // All filters off: last hits clear, count holds; status ignores writes
      wr(4'h0, 32'h0000_0000, 2'b00);
      frame(16'h0000);
      send <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      wr(4'hc, 32'hffff_ffff, 2'b00);
      rd(4'hc, {2'b00, n_acc[15:0], 16'h0000});
      $display("test done: status");
      end_sim();
   end
endmodule
`default_nettype wire
